// [design/cke_regs.svh]
/*
  timing and code constants for the console keyboard encoder.
  assumes a 40 MHz clock; included by its bare name.
*/
`ifndef CKE_REGS_SVH
`define CKE_REGS_SVH
`define CKE_CLK_HZ 40000000
`define CKE_ACT_MS 10
`define CKE_LATCH_MS 10
`define CKE_ACT_CYCLES ((`CKE_CLK_HZ / 1000) * `CKE_ACT_MS)
`define CKE_LATCH_CYCLES ((`CKE_CLK_HZ / 1000) * `CKE_LATCH_MS)
`define CKE_CODE_LEAD 5'h10
`define CKE_LOW_PLUS 4'hb
`define CKE_LOW_MINUS 4'ha
`define CKE_LOW_POINT 4'hc
`define CKE_LOW_CLEAR 4'hd
`define CKE_LOW_ENTER 4'he
`define CKE_KEY_PLUS 4'ha
`define CKE_KEY_MINUS 4'hb
`define CKE_KEY_POINT 4'hc
`define CKE_KEY_CLEAR 4'hd
`define CKE_KEY_ENTER 4'he
`define CKE_CNT_W 20
`endif

// [design/cke_pkg.sv]
/*
  types for the console keyboard encoder.
  assumes nothing beyond the header of constants.
*/
package cke_pkg;
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOCK = 3'b001,
    ST_RELEASE = 3'b010,
    ST_DRIVE = 3'b011,
    ST_LATCHING = 3'b100,
    ST_HELD = 3'b101
  } cke_state_type;
  typedef struct packed {
    logic valid;
    logic [4:0] code;
  } cke_code_type;
endpackage

// [design/cke_sync.sv]
/*
  two-flop synchroniser for the key pins.
  assumes inputs are asynchronous to clk_i.
*/
`timescale 1ns/1ps
module cke_sync #(
  parameter int WIDTH = 15
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // async in, synced out
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] meta;
  logic [WIDTH-1:0] next_meta;
  logic [WIDTH-1:0] stage;
  logic [WIDTH-1:0] next_stage;
  always_comb begin
    next_meta = async_i;
    next_stage = meta;
  end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      meta <= '0;
      stage <= '0;
    end else begin
      meta <= next_meta;
      stage <= next_stage;
    end
  end
  assign sync_o = stage;
endmodule

// [design/cke_encoder.sv]
/*
  console decimal keyboard encoder: turns one key press into a five-bit code
  for the computer input flip-flops, with lockout and antirepeat.
  assumes key pins are raw, active high, one bit per key; the consumer gates on fill select.
*/
`timescale 1ns/1ps
`include "cke_regs.svh"
module cke_encoder #(
  parameter int ACT_CYCLES = `CKE_ACT_CYCLES,
  parameter int LATCH_CYCLES = `CKE_LATCH_CYCLES
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // keys: 0..9 digits, 10 plus, 11 minus, 12 point, 13 clear, 14 enter
  input wire logic [14:0] key_i,
  // toward the computer
  output logic [4:0] code_o,
  output logic code_valid_o,
  output logic lock_o,
  output logic antirepeat_latch_o
);
  localparam logic [`CKE_CNT_W-1:0] ACT_LAST = `CKE_CNT_W'(ACT_CYCLES - 1);
  localparam logic [`CKE_CNT_W-1:0] LATCH_LAST = `CKE_CNT_W'(LATCH_CYCLES - 1);

  function automatic cke_pkg::cke_code_type encode(input logic [14:0] keys);
    cke_pkg::cke_code_type r;
    r = '0;
    // lowest index wins: a fixed priority stands in for which bar landed first
    for (int i = 14; i >= 0; i--) begin
      if (keys[i]) begin
        r.valid = 1'b1;
        if (i < 10) begin
          r.code = `CKE_CODE_LEAD | {1'b0, 4'(i)};
        end else begin
          case (4'(i))
            `CKE_KEY_PLUS: r.code = `CKE_CODE_LEAD | {1'b0, `CKE_LOW_PLUS};
            `CKE_KEY_MINUS: r.code = `CKE_CODE_LEAD | {1'b0, `CKE_LOW_MINUS};
            `CKE_KEY_POINT: r.code = `CKE_CODE_LEAD | {1'b0, `CKE_LOW_POINT};
            `CKE_KEY_CLEAR: r.code = `CKE_CODE_LEAD | {1'b0, `CKE_LOW_CLEAR};
            default: r.code = `CKE_CODE_LEAD | {1'b0, `CKE_LOW_ENTER};
          endcase
        end
      end
    end
    return r;
  endfunction

  logic [14:0] keys;
  cke_sync #(.WIDTH(15)) u_sync (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .async_i(key_i),
    .sync_o(keys)
  );

  cke_pkg::cke_state_type state;
  cke_pkg::cke_state_type next_state;
  logic [`CKE_CNT_W-1:0] cnt;
  logic [`CKE_CNT_W-1:0] next_cnt;
  logic [4:0] held_code;
  logic [4:0] next_held_code;
  logic [4:0] code;
  logic [4:0] next_code;
  logic code_valid;
  logic next_code_valid;
  logic lock;
  logic next_lock;
  logic latch;
  logic next_latch;
  cke_pkg::cke_code_type sel;
  logic any_key;

  always_comb begin
    sel = encode(keys);
    any_key = |keys;
    next_state = state;
    next_cnt = cnt + `CKE_CNT_W'(1);
    next_held_code = held_code;
    next_code = code;
    next_code_valid = 1'b0;
    next_lock = lock;
    next_latch = latch;
    case (state)
      cke_pkg::ST_IDLE: begin
        next_cnt = '0;
        if (sel.valid) begin
          next_held_code = sel.code;
          next_lock = 1'b1;
          next_state = cke_pkg::ST_LOCK;
        end
      end
      cke_pkg::ST_LOCK: begin
        next_state = cke_pkg::ST_RELEASE;
      end
      cke_pkg::ST_RELEASE: begin
        next_code = held_code;
        next_code_valid = 1'b1;
        next_state = cke_pkg::ST_DRIVE;
      end
      cke_pkg::ST_DRIVE: begin
        if (cnt >= ACT_LAST) begin
          next_cnt = '0;
          next_state = cke_pkg::ST_LATCHING;
        end
      end
      cke_pkg::ST_LATCHING: begin
        if (cnt >= LATCH_LAST) begin
          next_latch = 1'b1;
          next_lock = 1'b0;
          next_state = cke_pkg::ST_HELD;
        end
      end
      cke_pkg::ST_HELD: begin
        next_cnt = '0;
        // any key still down keeps the latch set, so a held key never repeats
        if (!any_key) begin
          next_latch = 1'b0;
          next_state = cke_pkg::ST_IDLE;
        end
      end
      default: begin
        next_state = cke_pkg::ST_IDLE;
        next_lock = 1'b0;
        next_latch = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= cke_pkg::ST_IDLE;
      cnt <= '0;
      held_code <= '0;
      code <= '0;
      code_valid <= 1'b0;
      lock <= 1'b0;
      latch <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      held_code <= next_held_code;
      code <= next_code;
      code_valid <= next_code_valid;
      lock <= next_lock;
      latch <= next_latch;
    end
  end

  assign code_o = code;
  assign code_valid_o = code_valid;
  assign lock_o = lock;
  assign antirepeat_latch_o = latch;

  property p_one_code;
    @(posedge clk_i) disable iff (!rst_n_i)
      code_valid |=> !code_valid;
  endproperty
  a_one_code: assert property (p_one_code) else $error("code pulse longer than one cycle");

  property p_lead_bit;
    @(posedge clk_i) disable iff (!rst_n_i)
      code_valid |-> code[4];
  endproperty
  a_lead_bit: assert property (p_lead_bit) else $error("code lacks leading one");

  property p_digit_map;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state == cke_pkg::ST_IDLE && keys == 15'h0001) |=> ##2 (code_valid && code == 5'h10);
  endproperty
  a_digit_map: assert property (p_digit_map) else $error("digit zero not coded 10000");

  property p_enter_map;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state == cke_pkg::ST_IDLE && keys == 15'h4000) |=> ##2 (code_valid && code == 5'h1e);
  endproperty
  a_enter_map: assert property (p_enter_map) else $error("enter not coded 11110");

  property p_order;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(lock) |-> !code_valid ##1 !code_valid ##1 code_valid;
  endproperty
  a_order: assert property (p_order) else $error("code not driven two cycles after lock");

  property p_lock_during_act;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state inside {cke_pkg::ST_LOCK, cke_pkg::ST_RELEASE, cke_pkg::ST_DRIVE}) |-> lock;
  endproperty
  a_lock_during_act: assert property (p_lock_during_act) else $error("keyboard unlocked in actuation");

  property p_latch_after;
    @(posedge clk_i) disable iff (!rst_n_i)
      $rose(latch) |-> $past(state) == cke_pkg::ST_LATCHING && !lock;
  endproperty
  a_latch_after: assert property (p_latch_after) else $error("latch set out of order");

  property p_held;
    @(posedge clk_i) disable iff (!rst_n_i)
      (latch && any_key) |=> latch && !code_valid;
  endproperty
  a_held: assert property (p_held) else $error("latch dropped while key down");

  property p_release;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state == cke_pkg::ST_HELD && !any_key) |=> (state == cke_pkg::ST_IDLE && !latch);
  endproperty
  a_release: assert property (p_release) else $error("no return to idle on release");

  property p_no_new_while_busy;
    @(posedge clk_i) disable iff (!rst_n_i)
      (state != cke_pkg::ST_IDLE) |=> !$rose(lock) && $stable(held_code);
  endproperty
  a_no_new_while_busy: assert property (p_no_new_while_busy) else $error("new press accepted while busy");
endmodule

// [tb/cke_fill_model.sv]
/*
  computer side model: input flip-flops feeding memory fill from the keyboard.
  assumes the code word is qualified by a one-cycle valid pulse.
*/
`timescale 1ns/1ps
module cke_fill_model (
  // clock
  input wire logic clk_i,
  // fill control
  input wire logic fill_sel_i,
  input wire logic [3:0] loc_i,
  // from the encoder
  input wire logic [4:0] code_i,
  input wire logic code_valid_i,
  // memory view
  output logic [4:0] word_o,
  output logic [7:0] taken_o
);
  logic [4:0] mem [16];
  logic [7:0] taken = 8'h00;
  assign word_o = mem[loc_i];
  assign taken_o = taken;
  always @(posedge clk_i) begin
    // codes outside fill selection are dropped, as the real input logic does
    if (code_valid_i === 1'b1 && fill_sel_i) begin
      mem[loc_i] <= code_i;
      taken <= taken + 8'h01;
    end
  end
endmodule

// [tb/testbench.sv]
/*
  self-checking bench for the keyboard encoder with a fill model behind it.
  assumes short actuation and latch counts set below.
*/
`timescale 1ns/1ps
module testbench;
  localparam int ACT = 8;
  localparam int LAT = 8;
  localparam logic [4:0] SYM [5] = '{5'h1b, 5'h1a, 5'h1c, 5'h1d, 5'h1e};
  logic clk_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic [14:0] key_i = 15'h0000;
  logic fill_sel = 1'b0;
  logic [3:0] loc = 4'h0;
  logic [4:0] code_o;
  logic code_valid_o, lock_o, antirepeat_latch_o;
  logic [4:0] word;
  logic [7:0] taken;
  logic [31:0] seed = 32'h47a02590;
  int mismatches = 0;
  int checks_done = 0;
  int valids = 0;
  int lock_len = 0;
  always #12.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    if (code_valid_o === 1'b1) valids++;
    if (lock_o === 1'b1) lock_len++;
  end
  cke_encoder #(.ACT_CYCLES(ACT), .LATCH_CYCLES(LAT)) i_cke_encoder (.clk_i(clk_i), .rst_n_i(rst_n_i),
    .key_i(key_i), .code_o(code_o), .code_valid_o(code_valid_o), .lock_o(lock_o),
    .antirepeat_latch_o(antirepeat_latch_o));
  cke_fill_model i_cke_fill_model (.clk_i(clk_i), .fill_sel_i(fill_sel), .loc_i(loc), .code_i(code_o),
    .code_valid_i(code_valid_o), .word_o(word), .taken_o(taken));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  // lowest pressed index wins
  function automatic logic [4:0] exp_code(input logic [14:0] k);
    for (int i = 0; i < 15; i++) begin
      if (k[i]) return (i < 10) ? {1'b1, 4'(i)} : SYM[i-10];
    end
    return 5'h00;
  endfunction
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // which: 0 watches code_valid_o, 1 watches antirepeat_latch_o
  task automatic wait_sig(input int which, input logic lvl, input int lim);
    int n;
    logic s;
    n = 0;
    s = (which == 0) ? code_valid_o : antirepeat_latch_o;
    while (s !== lvl && n < lim) begin
      @(posedge clk_i);
      #1;
      n++;
      s = (which == 0) ? code_valid_o : antirepeat_latch_o;
    end
    if (s !== lvl) begin
      mismatches++;
      report_and_stop();
    end
  endtask
  task automatic press(input logic [14:0] m, input logic fs, input logic [3:0] at);
    logic [7:0] t0;
    t0 = taken;
    valids = 0;
    lock_len = 0;
    @(posedge clk_i);
    key_i <= m;
    fill_sel <= fs;
    loc <= at;
    wait_sig(0, 1'b1, 20);
    chk(code_o, exp_code(m));
    chk(lock_o, 1'b1);
    seed = xs(seed);
    @(posedge clk_i);
    key_i <= m | seed[14:0];
    wait_sig(1, 1'b1, ACT + LAT + 10);
    chk(lock_o, 1'b0);
    chk(8'(lock_len >= ACT + LAT), 8'h01);
    repeat (10) @(posedge clk_i);
    #1;
    chk(8'(valids), 8'h01);
    chk(antirepeat_latch_o, 1'b1);
    @(posedge clk_i);
    key_i <= 15'h0000;
    wait_sig(1, 1'b0, 10);
    chk(lock_o, 1'b0);
    chk(code_o, exp_code(m));
    chk(taken, t0 + 8'(fs));
    if (fs) chk(word, exp_code(m));
    $display("press %h done", m);
  endtask
  initial begin
    repeat (8) @(posedge clk_i);
    rst_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    #1;
    chk({code_valid_o, lock_o, antirepeat_latch_o}, 8'h00);
    for (int i = 0; i < 15; i++) press(15'h0001 << i, 1'b1, 4'(i));
    press(15'h7fff, 1'b1, 4'h3);
    press(15'h4400, 1'b0, 4'h3);
    for (int i = 0; i < 12; i++) begin
      seed = xs(seed);
      press((seed[14:0] == 15'h0000) ? 15'h0100 : seed[14:0], seed[20], seed[24:21]);
    end
    report_and_stop();
  end
endmodule
